// ===== include/fuse_cfg_pkg.sv
// Constants for the fuse configuration decoder
package fuse_cfg_pkg;
    // Register offsets on the register port
    localparam logic [7:0] OFS_SYSCFG0 = 8'h05;
    localparam logic [7:0] OFS_STARTUP_TIME_CONFIG = 8'h06;
    localparam logic [7:0] OFS_APP_CODE_END = 8'h07;
    localparam logic [7:0] OFS_BOOT_SECTION_END = 8'h08;
    localparam logic [7:0] OFS_LOCK_STATE = 8'h0A;
    localparam logic [7:0] OFS_DECODE_STATUS = 8'h10;
    localparam logic [7:0] OFS_ERASE_CTRL = 8'h11;
    // Field positions in system configuration 0, and the start-up select width
    localparam int PRESERVE_EEPROM_BIT = 0;
    localparam int PIN_FUNC_LSB = 2;
    localparam int STARTUP_SEL_W = 3;
    // Encodings
    localparam logic [7:0] LOCK_OPEN_CODE = 8'hC5;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    typedef enum logic [1:0] {
        PIN_GPIO = 2'h0,
        PIN_RESET = 2'h1,
        PIN_DEBUG = 2'h2,
        PIN_DEBUG_ALT_RESET = 2'h3
    } pin_function_t;
    // Flash geometry: 256-byte blocks, 16-bit byte address
    localparam int BLOCK_SHIFT = 8;
    localparam int FLASH_AW = 16;
    localparam logic [FLASH_AW-1:0] FLASH_TOP = 16'h3FFF;
    // Start-up delay base: 1 ms at 125 MHz
    localparam int CLK_MHZ = 125;
    localparam int STARTUP_UNIT_MS = 1;
    localparam int MS_CYCLES = STARTUP_UNIT_MS * CLK_MHZ * 1000;
    localparam int DELAY_W = 24;
    typedef enum logic [1:0] {
        ST_SAMPLE = 2'b00,
        ST_DELAY = 2'b01,
        ST_RUN = 2'b10
    } boot_state_t;
endpackage

// ===== verilog/fuse_config_decode.sv
// Fuse configuration decoder with start-up delay and erase policy
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ps

module fuse_config_decode
    import fuse_cfg_pkg::*;
#(
    parameter int MS_CYCLES_P = fuse_cfg_pkg::MS_CYCLES,
    parameter bit PKG_24PIN = 1'b1
)
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic nrst_in,
    // Fuse array contents, static while sampled
    input wire logic [7:0] fuse_syscfg0_in,
    input wire logic [7:0] fuse_startup_in,
    input wire logic [7:0] fuse_app_end_in,
    input wire logic [7:0] fuse_boot_end_in,
    input wire logic [7:0] fuse_lock_in,
    // Chip erase request from the programmer
    input wire logic chip_erase_in,
    // Flash address to classify
    input wire logic [fuse_cfg_pkg::FLASH_AW-1:0] flash_addr_in,
    // Register port
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // Decoded configuration
    output logic pin_is_gpio_out,
    output logic pin_is_reset_out,
    output logic pin_is_debug_out,
    output logic alt_reset_en_out,
    output logic pin_cfg_reserved_out,
    output logic device_locked_out,
    output logic startup_done_out,
    output logic [fuse_cfg_pkg::FLASH_AW-1:0] boot_end_addr_out,
    output logic [fuse_cfg_pkg::FLASH_AW-1:0] app_end_addr_out,
    output logic addr_is_boot_out,
    output logic addr_is_app_code_out,
    output logic addr_is_app_data_out,
    output logic flash_erase_out,
    output logic eeprom_erase_out
);
    import fuse_cfg_pkg::*;

    logic [7:0] syscfg0_reg;
    logic [7:0] startup_reg;
    logic [7:0] app_end_reg;
    logic [7:0] boot_end_reg;
    logic [7:0] lock_reg;
    logic sampled_reg;
    boot_state_t state_reg;
    logic [DELAY_W-1:0] ms_cnt_reg;
    logic [7:0] ms_left_reg;
    logic erase_seen_reg;
    logic [1:0] erase_sync_reg;
    logic erase_prev_reg;
    logic erase_pulse;
    pin_function_t pin_fn;
    logic locked;
    logic [7:0] delay_ms;
    logic [FLASH_AW-1:0] boot_end_addr;
    logic [FLASH_AW-1:0] app_end_addr;
    logic [FLASH_AW-1:0] flash_addr;

    // Capture fuses in the first cycle after reset release, then freeze all but lock_reg, which register writes can change
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            syscfg0_reg <= BYTE_ZERO;
            startup_reg <= BYTE_ZERO;
            app_end_reg <= BYTE_ZERO;
            boot_end_reg <= BYTE_ZERO;
            lock_reg <= BYTE_ZERO;
            sampled_reg <= 1'b0;
        end
        else if (!sampled_reg)
        begin
            syscfg0_reg <= fuse_syscfg0_in;
            startup_reg <= fuse_startup_in;
            app_end_reg <= fuse_app_end_in;
            boot_end_reg <= fuse_boot_end_in;
            lock_reg <= fuse_lock_in;
            sampled_reg <= 1'b1;
        end
        else if (reg_wr_in && reg_addr_in == OFS_LOCK_STATE)
        begin
            lock_reg <= reg_wdata_in;
        end
    end

    assign pin_fn = pin_function_t'(syscfg0_reg[PIN_FUNC_LSB +: 2]);
    assign locked = (lock_reg != LOCK_OPEN_CODE);

    // Pin function decode
    always_comb
    begin
        pin_is_gpio_out = 1'b0;
        pin_is_reset_out = 1'b0;
        pin_is_debug_out = 1'b0;
        alt_reset_en_out = 1'b0;
        pin_cfg_reserved_out = 1'b0;
        if (sampled_reg)
        begin
            case (pin_fn)
                PIN_GPIO: pin_is_gpio_out = 1'b1;
                PIN_RESET: pin_is_reset_out = 1'b1;
                PIN_DEBUG: pin_is_debug_out = 1'b1;
                PIN_DEBUG_ALT_RESET:
                begin
                    pin_is_debug_out = PKG_24PIN;
                    alt_reset_en_out = PKG_24PIN;
                    pin_cfg_reserved_out = !PKG_24PIN;
                end
                default: pin_is_gpio_out = 1'b0;
            endcase
        end
    end

    assign device_locked_out = locked;

    // Start-up delay: ms count 2^(code-1), code 0 gives none
    always_comb
    begin
        delay_ms = BYTE_ZERO;
        if (startup_reg[STARTUP_SEL_W-1:0] != 3'h0)
        begin
            delay_ms = 8'h01 << (startup_reg[STARTUP_SEL_W-1:0] - 3'h1);
        end
    end

    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            state_reg <= ST_SAMPLE;
            ms_cnt_reg <= '0;
            ms_left_reg <= BYTE_ZERO;
        end
        else
        begin
            case (state_reg)
                ST_SAMPLE:
                begin
                    if (sampled_reg)
                    begin
                        ms_left_reg <= delay_ms;
                        ms_cnt_reg <= '0;
                        state_reg <= (delay_ms == BYTE_ZERO) ? ST_RUN : ST_DELAY;
                    end
                end
                ST_DELAY:
                begin
                    if (ms_cnt_reg == DELAY_W'(MS_CYCLES_P - 1))
                    begin
                        ms_cnt_reg <= '0;
                        ms_left_reg <= ms_left_reg - 8'h01;
                        if (ms_left_reg == 8'h01)
                        begin
                            state_reg <= ST_RUN;
                        end
                    end
                    else
                    begin
                        ms_cnt_reg <= ms_cnt_reg + DELAY_W'(1);
                    end
                end
                ST_RUN: state_reg <= ST_RUN;
                default: state_reg <= ST_SAMPLE;
            endcase
        end
    end

    assign startup_done_out = (state_reg == ST_RUN);

    // Flash section boundaries in 256-byte blocks
    assign boot_end_addr = FLASH_AW'({boot_end_reg, 8'h00});
    assign app_end_addr = FLASH_AW'({app_end_reg, 8'h00});
    assign boot_end_addr_out = boot_end_addr;
    assign app_end_addr_out = app_end_addr;
    assign flash_addr = flash_addr_in;

    always_comb
    begin
        addr_is_boot_out = 1'b0;
        addr_is_app_code_out = 1'b0;
        addr_is_app_data_out = 1'b0;
        if (boot_end_reg == BYTE_ZERO)
        begin
            addr_is_boot_out = 1'b1;
        end
        else if (flash_addr < boot_end_addr)
        begin
            addr_is_boot_out = 1'b1;
        end
        else if (app_end_reg == BYTE_ZERO || flash_addr < app_end_addr)
        begin
            addr_is_app_code_out = (flash_addr <= FLASH_TOP);
        end
        else
        begin
            addr_is_app_data_out = (flash_addr <= FLASH_TOP);
        end
    end

    // Chip erase comes from the programmer pin: synchronise, then edge-detect
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            erase_sync_reg <= 2'h0;
            erase_prev_reg <= 1'b0;
        end
        else
        begin
            erase_sync_reg <= {erase_sync_reg[0], chip_erase_in};
            erase_prev_reg <= erase_sync_reg[1];
        end
    end

    assign erase_pulse = erase_sync_reg[1] && !erase_prev_reg;

    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            flash_erase_out <= 1'b0;
            eeprom_erase_out <= 1'b0;
            erase_seen_reg <= 1'b0;
        end
        else
        begin
            flash_erase_out <= erase_pulse;
            eeprom_erase_out <= erase_pulse &&
                (locked || !syscfg0_reg[PRESERVE_EEPROM_BIT]);
            erase_seen_reg <= erase_seen_reg || erase_pulse;
        end
    end

    // Register reads, data one cycle after the strobe
    always_ff @(posedge sys_clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            reg_rdata_out <= BYTE_ZERO;
        end
        else if (reg_rd_in)
        begin
            if (reg_addr_in == OFS_SYSCFG0)
                reg_rdata_out <= syscfg0_reg;
            else if (reg_addr_in == OFS_STARTUP_TIME_CONFIG)
                reg_rdata_out <= {5'h00, startup_reg[STARTUP_SEL_W-1:0]};
            else if (reg_addr_in == OFS_APP_CODE_END)
                reg_rdata_out <= app_end_reg;
            else if (reg_addr_in == OFS_BOOT_SECTION_END)
                reg_rdata_out <= boot_end_reg;
            else if (reg_addr_in == OFS_LOCK_STATE)
                reg_rdata_out <= lock_reg;
            else if (reg_addr_in == OFS_DECODE_STATUS)
                reg_rdata_out <= {4'h0, erase_seen_reg, locked, startup_done_out, sampled_reg};
            else
                reg_rdata_out <= BYTE_ZERO;
        end
        else
        begin
            reg_rdata_out <= BYTE_ZERO;
        end
    end

    // Checks
    property p_lock_decode;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        device_locked_out == (lock_reg != LOCK_OPEN_CODE);
    endproperty
    a_lock_decode: assert property (p_lock_decode) else $error("lock decode wrong");

    property p_eeprom_locked;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        (erase_pulse && device_locked_out) |=> eeprom_erase_out;
    endproperty
    a_eeprom_locked: assert property (p_eeprom_locked) else $error("locked erase kept eeprom");

    property p_eeprom_keep;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        (erase_pulse && !device_locked_out && syscfg0_reg[0]) |=> !eeprom_erase_out;
    endproperty
    a_eeprom_keep: assert property (p_eeprom_keep) else $error("eeprom erased despite preserve");

    property p_eeprom_clear;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        (erase_pulse && !syscfg0_reg[0]) |=> eeprom_erase_out && flash_erase_out;
    endproperty
    a_eeprom_clear: assert property (p_eeprom_clear) else $error("eeprom not erased");

    property p_fuse_hold;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        $past(sampled_reg) |-> $stable(app_end_reg) && $stable(boot_end_reg) && $stable(syscfg0_reg);
    endproperty
    a_fuse_hold: assert property (p_fuse_hold) else $error("fuse copy changed");

    property p_pin_onehot;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        sampled_reg && syscfg0_reg[3:2] == 2'h1 |-> pin_is_reset_out && !pin_is_debug_out;
    endproperty
    a_pin_onehot: assert property (p_pin_onehot) else $error("reset pin function wrong");

    property p_pin_alt;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        sampled_reg && syscfg0_reg[3:2] == 2'h3 |-> alt_reset_en_out == PKG_24PIN;
    endproperty
    a_pin_alt: assert property (p_pin_alt) else $error("alternate reset wrong");

    property p_zero_delay;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        (state_reg == ST_SAMPLE && sampled_reg && startup_reg[2:0] == 3'h0) |=> startup_done_out;
    endproperty
    a_zero_delay: assert property (p_zero_delay) else $error("zero delay not immediate");

    property p_app_end;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        app_end_addr_out == {app_end_reg, 8'h00} && boot_end_addr_out == {boot_end_reg, 8'h00};
    endproperty
    a_app_end: assert property (p_app_end) else $error("section address wrong");

    property p_one_section;
        @(posedge sys_clk_in) disable iff (!nrst_in)
        !(addr_is_boot_out && (addr_is_app_code_out || addr_is_app_data_out));
    endproperty
    a_one_section: assert property (p_one_section) else $error("address in two sections");

    c_locked_erase: cover property (@(posedge sys_clk_in) erase_pulse && device_locked_out);
    c_startup_done: cover property (@(posedge sys_clk_in) $rose(startup_done_out));
    c_app_data: cover property (@(posedge sys_clk_in) addr_is_app_data_out);
endmodule // fuse_config_decode

// ===== dv/fuse_config_decode_tb.sv
// Self-checking testbench for the fuse configuration decoder
`timescale 1ns/1ps
module fuse_config_decode_tb;
    import fuse_cfg_pkg::*;
    localparam int MS_P = 10;
    logic sys_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [7:0] cfg0 = 8'h00;
    logic [7:0] startup_fuse = 8'h00;
    logic [7:0] app = 8'h00;
    logic [7:0] boot = 8'h00;
    logic [7:0] lock = 8'h00;
    logic erase = 1'b0;
    logic [15:0] faddr = 16'h0000;
    logic [7:0] raddr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [7:0] rdata;
    logic gpio, rstp, dbg, alt, rsv, locked, done, isb, isc, isd, fer, eer;
    logic dbg_s, alt_s, rsv_s;
    logic [15:0] bend;
    logic [15:0] aend;
    int err_count = 0;
    int cmp_count = 0;

    fuse_config_decode #(.MS_CYCLES_P(MS_P), .PKG_24PIN(1'b1)) dut (
        .sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
        .fuse_syscfg0_in(cfg0), .fuse_startup_in(startup_fuse), .fuse_app_end_in(app),
        .fuse_boot_end_in(boot), .fuse_lock_in(lock), .chip_erase_in(erase),
        .flash_addr_in(faddr), .reg_addr_in(raddr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .pin_is_gpio_out(gpio), .pin_is_reset_out(rstp), .pin_is_debug_out(dbg),
        .alt_reset_en_out(alt), .pin_cfg_reserved_out(rsv), .device_locked_out(locked),
        .startup_done_out(done), .boot_end_addr_out(bend), .app_end_addr_out(aend),
        .addr_is_boot_out(isb), .addr_is_app_code_out(isc), .addr_is_app_data_out(isd),
        .flash_erase_out(fer), .eeprom_erase_out(eer)
    );

    // Smaller package: the shared pin's fourth code is reserved
    fuse_config_decode #(.MS_CYCLES_P(MS_P), .PKG_24PIN(1'b0)) dut_small (
        .sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
        .fuse_syscfg0_in(cfg0), .fuse_startup_in(startup_fuse), .fuse_app_end_in(app),
        .fuse_boot_end_in(boot), .fuse_lock_in(lock), .chip_erase_in(erase),
        .flash_addr_in(faddr), .reg_addr_in(raddr), .reg_wdata_in(wdata),
        .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(),
        .pin_is_gpio_out(), .pin_is_reset_out(), .pin_is_debug_out(dbg_s),
        .alt_reset_en_out(alt_s), .pin_cfg_reserved_out(rsv_s), .device_locked_out(),
        .startup_done_out(), .boot_end_addr_out(), .app_end_addr_out(),
        .addr_is_boot_out(), .addr_is_app_code_out(), .addr_is_app_data_out(),
        .flash_erase_out(), .eeprom_erase_out()
    );

    initial
    begin
        forever #4 sys_clk_in = ~sys_clk_in;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Fuses are presented during reset and must stay put across the release edge
    task automatic boot_dev(input logic [7:0] c0, s, a, b, l);
        @(posedge sys_clk_in);
        nrst_in <= 1'b0;
        cfg0 <= c0;
        startup_fuse <= s;
        app <= a;
        boot <= b;
        lock <= l;
        repeat (16) @(posedge sys_clk_in);
        chk("locked in reset", 16'h1, {15'h0, locked});
        chk("pins in reset", 16'h0, {11'h0, gpio, rstp, dbg, alt, rsv});
        nrst_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
    endtask

    task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk_in);
        raddr <= a;
        rd <= 1'b1;
        @(posedge sys_clk_in);
        rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk_in);
        raddr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge sys_clk_in);
        wr <= 1'b0;
    endtask

    task automatic chk_addr(input logic [15:0] a, input logic [2:0] exp);
        @(posedge sys_clk_in);
        faddr <= a;
        #1 chk("section flags", {13'h0, exp}, {13'h0, isb, isc, isd});
    endtask

    task automatic test_pins();
        for (int i = 0; i < 4; i++)
        begin
            boot_dev({4'h0, i[1:0], 2'b00}, 8'h00, 8'h00, 8'h00, LOCK_OPEN_CODE);
            chk("gpio", {15'h0, i == 0}, {15'h0, gpio});
            chk("reset pin", {15'h0, i == 1}, {15'h0, rstp});
            chk("debug pin", {15'h0, i >= 2}, {15'h0, dbg});
            chk("alt reset", {15'h0, i == 3}, {15'h0, alt});
            chk("reserved", 16'h0, {15'h0, rsv});
            chk("small debug", {15'h0, i == 2}, {15'h0, dbg_s});
            chk("small alt reset", 16'h0, {15'h0, alt_s});
            chk("small reserved", {15'h0, i == 3}, {15'h0, rsv_s});
            cfg0 <= ~cfg0;
            repeat (3) @(posedge sys_clk_in);
            chk("held debug", {15'h0, i >= 2}, {15'h0, dbg});
        end
    endtask

    task automatic test_startup();
        int k;
        int n;
        logic [7:0] d;
        for (int c = 0; c < 8; c++)
        begin
            boot_dev(8'h00, c[7:0], 8'h00, 8'h00, LOCK_OPEN_CODE);
            n = (c == 0) ? 0 : (MS_P << (c - 1));
            k = 0;
            while (done !== 1'b1 && k < 800)
            begin
                @(posedge sys_clk_in);
                #1 k++;
            end
            chk("delay not short", 16'h1, {15'h0, k + 3 >= n});
            chk("delay not long", 16'h1, {15'h0, k + 3 <= n + 5});
            reg_read(OFS_STARTUP_TIME_CONFIG, d);
            chk("startup reg", {13'h0, c[2:0]}, {13'h0, d[2:0]});
        end
    endtask

    task automatic test_sections();
        logic [7:0] d;
        boot_dev(8'h00, 8'h00, 8'h05, 8'h02, LOCK_OPEN_CODE);
        chk("boot end addr", 16'h0200, bend);
        chk("app end addr", 16'h0500, aend);
        chk_addr(16'h01FF, 3'b100);
        chk_addr(16'h0200, 3'b010);
        chk_addr(16'h04FF, 3'b010);
        chk_addr(16'h0500, 3'b001);
        chk_addr(16'h3FFF, 3'b001);
        reg_write(OFS_APP_CODE_END, 8'hFF);
        reg_read(OFS_APP_CODE_END, d);
        chk("app end reg", 16'h0005, {8'h0, d});
        reg_read(OFS_BOOT_SECTION_END, d);
        chk("boot end reg", 16'h0002, {8'h0, d});
        boot_dev(8'h00, 8'h00, 8'h00, 8'h03, LOCK_OPEN_CODE);
        chk_addr(16'h02FF, 3'b100);
        chk_addr(16'h0300, 3'b010);
        chk_addr(16'h3FFF, 3'b010);
        boot_dev(8'h00, 8'h00, 8'h00, 8'h00, LOCK_OPEN_CODE);
        chk_addr(16'h3FFF, 3'b100);
        boot_dev(8'h00, 8'h00, 8'h05, 8'h00, LOCK_OPEN_CODE);
        chk_addr(16'h0600, 3'b100);
    endtask

    task automatic test_lock();
        logic [7:0] d;
        boot_dev(8'h00, 8'h00, 8'h00, 8'h00, LOCK_OPEN_CODE);
        chk("open", 16'h0, {15'h0, locked});
        boot_dev(8'h00, 8'h00, 8'h00, 8'h00, 8'hC4);
        chk("locked C4", 16'h1, {15'h0, locked});
        reg_read(OFS_LOCK_STATE, d);
        chk("lock reg", 16'h00C4, {8'h0, d});
        reg_write(OFS_LOCK_STATE, LOCK_OPEN_CODE);
        reg_read(OFS_LOCK_STATE, d);
        chk("lock reg written", 16'h00C5, {8'h0, d});
        chk("open after write", 16'h0, {15'h0, locked});
        reg_read(8'h11, d);
        chk("unmapped read", 16'h0, {8'h0, d});
    endtask

    task automatic erase_case(input logic keep, input logic [7:0] l, input logic exp_ee);
        int n;
        logic e;
        logic [7:0] d;
        boot_dev({7'h0, keep}, 8'h00, 8'h00, 8'h00, l);
        n = 0;
        e = 1'b0;
        @(posedge sys_clk_in);
        erase <= 1'b1;
        repeat (10)
        begin
            @(posedge sys_clk_in);
            #1;
            if (fer === 1'b1)
            begin
                n++;
                e = eer;
            end
        end
        @(posedge sys_clk_in);
        erase <= 1'b0;
        chk("erase pulses", 16'h1, n[15:0]);
        chk("eeprom erase", {15'h0, exp_ee}, {15'h0, e});
        reg_read(OFS_DECODE_STATUS, d);
        chk("status reg", {12'h0, 1'b1, l != LOCK_OPEN_CODE, 2'b11}, {8'h0, d});
        reg_read(OFS_SYSCFG0, d);
        chk("pin erase reg", {15'h0, keep}, {8'h0, d});
        repeat (4) @(posedge sys_clk_in);
    endtask

    task automatic end_sim();
        if (err_count == 0 && cmp_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        #400000;
        err_count++;
        end_sim();
    end

    initial
    begin
        test_pins();
        test_startup();
        test_sections();
        test_lock();
        erase_case(1'b1, LOCK_OPEN_CODE, 1'b0);
        erase_case(1'b0, LOCK_OPEN_CODE, 1'b1);
        erase_case(1'b1, 8'hC4, 1'b1);
        end_sim();
    end
endmodule // fuse_config_decode_tb
